// ===== src/pcp_power_cmd.sv
`timescale 1ns/100ps
module pcp_power_cmd #(
    parameter int CLR_CYCLES = pcp_pkg::CLR_CYCLES_DEF
) (
    input wire logic clock_i, // System clock, 200 MHz.
    input wire logic rst_b_i, // Asynchronous reset, active low.
    input wire logic wr_i, // Register write strobe.
    input wire logic rd_i, // Register read strobe.
    input wire logic [7:0] addr_i, // Register command offset.
    input wire logic [7:0] wdata_i, // Register write data.
    output logic [7:0] rdata_o, // Register read data.
    input wire logic [7:0] mode_i, // Two mode bits per channel.
    input wire logic [1:0] pair4_i, // Port wired for 4-pair.
    input wire logic [1:0] single_sig_i, // Port load is single signature.
    input wire logic [3:0] high_class_i, // Assigned class five or higher.
    input wire logic [3:0] cycle_done_i, // Discovery cycle finished.
    input wire logic [3:0] cls_active_i, // Classification running.
    input wire logic [3:0] cls_valid_i, // Class result valid.
    input wire logic [3:0] alloc_ok_i, // Allocation suffices.
    output logic [3:0] start_cycle_o, // Single cycle request pulses.
    output logic [3:0] power_en_o, // Channel power enables.
    output logic [3:0] chan_clear_o, // Channel field clearing window.
    output logic [3:0] cooldown_abort_o, // Cool-down abort pulses.
    output logic reset_all_o, // Group reset pulse.
    output logic irq_b_o // Interrupt output, active low.
);
    localparam int N = pcp_pkg::NUM_CH;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    if (CLR_CYCLES < 2)
    begin : g_chk
        $error("CLR_CYCLES must be at least two");
    end

    // ==========================================================
    // Command decode
    logic wr_pwr;
    logic wr_rst;
    logic wr_detcls;
    logic wr_evt;
    logic [N-1:0] pwon_raw;
    logic [N-1:0] off_raw;
    logic [N-1:0] resp_raw;
    logic reset_all;
    logic clr_all;
    logic rel_cmd;

    assign wr_pwr = wr_i && (addr_i == pcp_pkg::PWR_OFS);
    assign wr_rst = wr_i && (addr_i == pcp_pkg::RST_OFS);
    assign wr_detcls = wr_i && (addr_i == pcp_pkg::DETCLS_OFS);
    assign wr_evt = wr_i && (addr_i == pcp_pkg::EVT_OFS);
    assign pwon_raw = wr_pwr ? wdata_i[pcp_pkg::PWON_LSB +: N] : '0;
    assign off_raw = wr_pwr ? wdata_i[pcp_pkg::POFF_LSB +: N] : '0;
    // Reset bits are pulses taken from the write itself; nothing is stored.
    assign resp_raw = wr_rst ? wdata_i[pcp_pkg::RESP_LSB +: N] : '0;
    assign reset_all = wr_rst && wdata_i[pcp_pkg::RESET_ALL_TRIGGER_BIT];
    assign clr_all = wr_rst && wdata_i[pcp_pkg::CLEAR_ALL_INTERRUPTS_BIT];
    assign rel_cmd = wr_rst && wdata_i[pcp_pkg::RELEASE_IRQ_PIN_BIT];

    // ==========================================================
    // Per-channel command routing
    logic [N-1:0] pwon_eff;
    logic [N-1:0] off_vec;
    logic [N-1:0] rst_vec;
    logic [N-1:0] clr_vec;
    logic [N-1:0] repower_ok;
    logic [N-1:0] auto_mode;
    logic [7:0] detcls_reg;
    logic [7:0] detcls_next;
    logic [7:0] pol_reg [N];

    for (genvar n = 0; n < N; n++)
    begin : g_ch
        localparam int P = n ^ 1;
        localparam int PT = n / 2;
        logic [7:0] pol_next;

        assign auto_mode[n] = (mode_i[2*n +: 2] == pcp_pkg::MODE_AUTO);
        // Off in the same write beats on; a lone request on a 4-pair port in
        // auto mode is dropped because the pair must come up together.
        assign pwon_eff[n] = pwon_raw[n] && !off_raw[n]
            && !(auto_mode[n] && pair4_i[PT] && !pwon_raw[P]);
        assign off_vec[n] = off_raw[n] || (off_raw[P] && pair4_i[PT] && single_sig_i[PT]
            && (high_class_i[n] || high_class_i[P]));
        assign rst_vec[n] = resp_raw[n] || (resp_raw[P] && pair4_i[PT]);
        assign clr_vec[n] = off_vec[n] || rst_vec[n] || reset_all;
        assign repower_ok[n] = pair4_i[PT] && !single_sig_i[PT] && power_en_o[P]
            && cls_valid_i[n];
        assign pol_next = clr_vec[n] ? pcp_pkg::POL_RST
            : (wr_i && addr_i == pcp_pkg::POL_OFS + 8'(n)) ? wdata_i : pol_reg[n];

        always_ff @(posedge clock_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
                pol_reg[n] <= pcp_pkg::POL_RST;
            else
                pol_reg[n] <= pol_next;
        end

        pcp_chan_seq u_seq (
            .clock_i(clock_i),
            .rst_b_i(rst_b_i),
            .mode_i(mode_i[2*n +: 2]),
            .det_en_i(detcls_reg[pcp_pkg::DETE_LSB + n]),
            .cls_en_i(detcls_reg[pcp_pkg::CLE_LSB + n]),
            .pwon_i(pwon_eff[n]),
            .off_i(clr_vec[n]),
            .cycle_done_i(cycle_done_i[n]),
            .cls_active_i(cls_active_i[n]),
            .cls_valid_i(cls_valid_i[n]),
            .alloc_ok_i(alloc_ok_i[n]),
            .repower_ok_i(repower_ok[n]),
            .start_cycle_o(start_cycle_o[n]),
            .power_en_o(power_en_o[n])
        );

        // The wider fields live in the measurement engine, which clears them
        // while this window is open.
        pcp_hold_timer #(
            .CYCLES(CLR_CYCLES)
        ) u_clr (
            .clock_i(clock_i),
            .rst_b_i(rst_b_i),
            .start_i(clr_vec[n]),
            .busy_o(chan_clear_o[n])
        );
    end

    // ==========================================================
    // Detect and class enables
    logic [7:0] en_clr_mask;

    assign en_clr_mask = {clr_vec, clr_vec};
    assign detcls_next = (wr_detcls ? wdata_i : detcls_reg) & ~en_clr_mask;

    // ==========================================================
    // Events and interrupt pin
    logic [N-1:0] pwr_prev_reg;
    logic [7:0] ev_set;
    logic [7:0] evt_reg;
    logic [7:0] evt_next;
    logic [7:0] evt_kept;
    logic rel_reg;
    logic rel_next;
    logic pending;
    logic [N-1:0] abort_reg;
    logic reset_all_reg;

    assign ev_set = {pwr_prev_reg & ~power_en_o, ~pwr_prev_reg & power_en_o};
    assign evt_kept = (clr_all || reset_all) ? pcp_pkg::EVT_RST
        : evt_reg & ~(wr_evt ? wdata_i : 8'h00);
    // A new event in the clearing cycle survives: set wins over clear.
    assign evt_next = evt_kept | ev_set;
    assign pending = (evt_reg != 8'h00);
    // The release holds until the event register drains, so events that
    // arrive meanwhile cannot pull the pin low again.
    assign rel_next = !reset_all && (rel_cmd || (rel_reg && pending));
    assign irq_b_o = !(pending && !rel_reg);
    assign cooldown_abort_o = abort_reg;
    assign reset_all_o = reset_all_reg;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            detcls_reg <= pcp_pkg::DETCLS_RST;
            evt_reg <= pcp_pkg::EVT_RST;
            rel_reg <= 1'b0;
            pwr_prev_reg <= '0;
            abort_reg <= '0;
            reset_all_reg <= 1'b0;
        end
        else
        begin
            detcls_reg <= detcls_next;
            evt_reg <= evt_next;
            rel_reg <= rel_next;
            pwr_prev_reg <= power_en_o;
            abort_reg <= rst_vec;
            reset_all_reg <= reset_all;
        end
    end

    // ==========================================================
    // Read path
    logic [7:0] rd_mux;
    logic [7:0] rdata_reg;
    logic pol_hit;
    logic [7:0] pol_idx;

    assign pol_idx = addr_i - pcp_pkg::POL_OFS;
    assign pol_hit = (addr_i >= pcp_pkg::POL_OFS) && (pol_idx < 8'(N));
    // Write-only command registers read back as zero, like unmapped offsets.
    assign rd_mux = (addr_i == pcp_pkg::EVT_OFS) ? evt_reg
        : (addr_i == pcp_pkg::PSTAT_OFS) ? {4'h0, power_en_o}
        : (addr_i == pcp_pkg::DETCLS_OFS) ? detcls_reg
        : pol_hit ? pol_reg[pol_idx[1:0]]
        : pcp_pkg::RD_NONE;
    assign rdata_o = rdata_reg;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_reg <= pcp_pkg::RD_NONE;
        else if (rd_i)
            rdata_reg <= rd_mux;
    end

    // ==========================================================
    // Checks
    off_pwr_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        clr_vec != '0 |=> (power_en_o & $past(clr_vec)) == '0)
        else $error("channel stayed powered after turn-off");

    keep_other_a: assert property (
        clr_vec == 4'h1 && !(wr_i && addr_i == pcp_pkg::POL_OFS + 8'h01)
        |=> $stable(pol_reg[1]))
        else $error("other channel touched");
    pol_reload_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        clr_vec[0] |=> pol_reg[0] == pcp_pkg::POL_RST)
        else $error("policing not reloaded");

    en_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        clr_vec != '0 |=> (detcls_reg & {$past(clr_vec), $past(clr_vec)}) == 8'h00)
        else $error("enables of cleared channel kept");

    clr_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        clr_vec[0] |=> chan_clear_o[0] [*2])
        else $error("clearing window too short");

    rst_abort_a: assert property (
        rst_vec[0] |=> cooldown_abort_o[0] && chan_clear_o[0])
        else $error("channel reset lost abort");
    rst_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rd_i && addr_i == pcp_pkg::RST_OFS |=> rdata_o == pcp_pkg::RD_NONE)
        else $error("reset register read not zero");

    zero_wr_a: assert property (
        wr_rst && wdata_i == 8'h00 |=> cooldown_abort_o == '0 && !reset_all_o)
        else $error("zero write acted");
    clr_all_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        clr_all && ev_set == 8'h00 |=> evt_reg == 8'h00 && irq_b_o)
        else $error("clear-all left events");

    // Events raised in the reset cycle itself survive it, as for clear-all.
    reset_all_a: assert property (
        reset_all |=> power_en_o == '0 && reset_all_o && detcls_reg == pcp_pkg::DETCLS_RST
        && evt_reg == $past(ev_set))
        else $error("reset-all left state");
    pin_rel_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rel_cmd && !reset_all |=> irq_b_o && evt_reg == $past(evt_kept | ev_set))
        else $error("release touched events or pin");

    chan_rst_a: assert property (
        resp_raw[1] |=> !power_en_o[1] && cooldown_abort_o[1])
        else $error("channel reset left power on");
    rel_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rel_reg && pending |-> irq_b_o)
        else $error("pin asserted during release");

    // Only an idle sequencer takes a request, so its state is looked at here.
    repower_a: assert property (
        pwon_eff[3] && repower_ok[3] && alloc_ok_i[3] && mode_i[7] && !clr_vec[3]
        && g_ch[3].u_seq.state_reg == pcp_pkg::ST_IDLE |=> power_en_o[3])
        else $error("dual-signature channel not repowered");
    lone_pwon_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        auto_mode[0] && pair4_i[0] && pwon_raw[0] && !pwon_raw[1] |-> !pwon_eff[0])
        else $error("lone request accepted in auto mode");

    auto_on_a: assert property (
        mode_i[7:6] == pcp_pkg::MODE_AUTO && detcls_reg[3] && detcls_reg[7] && cycle_done_i[3]
        && cls_valid_i[3] && alloc_ok_i[3] && !clr_vec[3]
        && g_ch[3].u_seq.state_reg == pcp_pkg::ST_IDLE |=> power_en_o[3])
        else $error("auto channel did not power up");
    pair_rst_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        resp_raw[0] && pair4_i[0] |=> cooldown_abort_o[1] && !power_en_o[1])
        else $error("pair partner not reset");

    one_start_a: assert property (
        start_cycle_o[2] |-> !power_en_o[2] ##1 !start_cycle_o[2])
        else $error("cycle request repeated");
    hi_off_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        off_raw[0] && pair4_i[0] && single_sig_i[0] && high_class_i[0] |=> !power_en_o[1])
        else $error("partner of high-class port kept on");

    // ==========================================================
    // Covers
    on_cov_c: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        !power_en_o[0] ##1 power_en_o[0]);

    off_cov_c: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        power_en_o[0] && off_raw[0]);

    rel_cov_c: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        rel_reg && pending ##1 !pending);

    rall_cov_c: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        reset_all && power_en_o != '0);

    rep_cov_c: cover property (pwon_eff[3] && repower_ok[3] && !power_en_o[3]);
endmodule

// ===== src/pcp_pkg.sv
// Notes on behaviour
// - Semi mode, both enables on: request turns on once after next or current cycle.
// - Semi mode, an enable off: request runs one full cycle, then one turn-on try.
// - Semi mode request before classification starts powers right after classification.
// - Auto mode, an enable off: request runs one cycle, then powers if valid.
// - Auto mode, both enables on: channel powers by itself after any cycle that ends valid with allocation ok.
// - Auto mode ignores a power-on request for one channel of a 4-pair port.
// - Power-off disables at once, clears channel state, reloads policing to all ones.
// - Clearing touches only the addressed channel, never the channels still operating.
// - Power-off clearing of every field completes within five milliseconds.
// - Power-off on one channel of a class 5+ single-signature port disables both.
// - Dual-signature channel turned off repowers on request if results stay valid.
// - Reset command bits are self-clearing triggers; zero writes do nothing.
// - Bit 7 clears all events and interrupt bits and releases the interrupt pin.
// - Bit 6 releases the interrupt pin and leaves the event contents alone.
// - After a release, the pin stays high until every pending interrupt is cleared.
// - Bit 4 returns registers to power-up values except the preserved set.
// - Reset-all acts on this group of four channels only.
// - Bits 3 to 0 turn off their channel at once, clearing as a power-off.
// - Channel reset hits both channels of a 4-pair port and aborts cool-down.
// - Channel reset clearing completes within five milliseconds.
package pcp_pkg;

    localparam int NUM_CH = 4;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] EVT_OFS = 8'h02;
    localparam logic [7:0] PSTAT_OFS = 8'h10;
    localparam logic [7:0] DETCLS_OFS = 8'h14;
    localparam logic [7:0] PWR_OFS = 8'h19;
    localparam logic [7:0] RST_OFS = 8'h1A;
    localparam logic [7:0] POL_OFS = 8'h1E;

    // ==========================================================
    // Field positions and reset values
    localparam int PWON_LSB = 0;
    localparam int POFF_LSB = 4;
    localparam int DETE_LSB = 0;
    localparam int CLE_LSB = 4;
    localparam int EVT_ON_LSB = 0;
    localparam int EVT_OFF_LSB = 4;
    localparam int RESP_LSB = 0;
    localparam int RESET_ALL_TRIGGER_BIT = 4;
    localparam int RELEASE_IRQ_PIN_BIT = 6;
    localparam int CLEAR_ALL_INTERRUPTS_BIT = 7;
    localparam logic [7:0] DETCLS_RST = 8'h00;
    localparam logic [7:0] EVT_RST = 8'h00;
    localparam logic [7:0] POL_RST = 8'hFF;
    localparam logic [7:0] RD_NONE = 8'h00;

    // ==========================================================
    // Operating modes, two bits per channel
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_SEMI = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLR_TIME_US = 5000;
    localparam int CLR_CYCLES_DEF = (CLR_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ARMED, ST_ON} pcp_chan_state_t;

endpackage

// ===== src/pcp_hold_timer.sv
`timescale 1ns/100ps
module pcp_hold_timer #(
    parameter int CYCLES = 16
) (
    input wire logic clock_i, // System clock.
    input wire logic rst_b_i, // Asynchronous reset, active low.
    input wire logic start_i, // Restarts the hold window.
    output logic busy_o // High while the window runs.
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    if (CYCLES < 2)
    begin : g_chk
        $error("pcp_hold_timer needs at least two cycles");
    end

    assign cnt_next = start_i ? W'(CYCLES) : (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    assign busy_o = (cnt_reg != '0);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// ===== src/pcp_chan_seq.sv
`timescale 1ns/100ps
module pcp_chan_seq (
    input wire logic clock_i, // System clock.
    input wire logic rst_b_i, // Asynchronous reset, active low.
    input wire logic [1:0] mode_i, // Operating mode of this channel.
    input wire logic det_en_i, // Detection cycling enabled.
    input wire logic cls_en_i, // Classification cycling enabled.
    input wire logic pwon_i, // Power-on request pulse.
    input wire logic off_i, // Turn-off pulse, any cause.
    input wire logic cycle_done_i, // Detection and class cycle finished.
    input wire logic cls_active_i, // Classification in progress.
    input wire logic cls_valid_i, // Class result valid.
    input wire logic alloc_ok_i, // Allocation suffices.
    input wire logic repower_ok_i, // Dual-signature partner still powered.
    output logic start_cycle_o, // Pulse asking for one single cycle.
    output logic power_en_o // Channel power enable.
);
    pcp_pkg::pcp_chan_state_t state_reg;
    pcp_pkg::pcp_chan_state_t state_next;
    logic cur_reg;
    logic cur_next;
    logic start_reg;
    logic start_next;
    logic both_en;
    logic attempt_ok;
    logic is_semi;
    logic is_auto;

    assign both_en = det_en_i && cls_en_i;
    assign attempt_ok = cls_valid_i && alloc_ok_i;
    assign is_semi = (mode_i == pcp_pkg::MODE_SEMI);
    assign is_auto = (mode_i == pcp_pkg::MODE_AUTO);

    always_comb
    begin
        state_next = state_reg;
        cur_next = cur_reg;
        start_next = 1'b0;
        case (state_reg)
            pcp_pkg::ST_IDLE:
            begin
                if (pwon_i && mode_i == pcp_pkg::MODE_MANUAL)
                    state_next = pcp_pkg::ST_ON;
                else if (pwon_i && (is_semi || is_auto) && repower_ok_i)
                    state_next = alloc_ok_i ? pcp_pkg::ST_ON : pcp_pkg::ST_IDLE;
                else if (pwon_i && is_semi && both_en)
                begin
                    state_next = pcp_pkg::ST_ARMED;
                    cur_next = !cls_active_i;
                end
                else if (pwon_i && (is_semi || is_auto) && !both_en)
                begin
                    state_next = pcp_pkg::ST_WAIT;
                    start_next = 1'b1;
                end
                else if (is_auto && both_en && cycle_done_i && attempt_ok)
                    state_next = pcp_pkg::ST_ON;
            end
            pcp_pkg::ST_WAIT:
                if (cycle_done_i)
                    state_next = attempt_ok ? pcp_pkg::ST_ON : pcp_pkg::ST_IDLE;
            pcp_pkg::ST_ARMED:
                if (cycle_done_i && cur_reg)
                    state_next = attempt_ok ? pcp_pkg::ST_ON : pcp_pkg::ST_IDLE;
                else if (cycle_done_i)
                    cur_next = 1'b1;
            pcp_pkg::ST_ON:
                if (mode_i == pcp_pkg::MODE_OFF)
                    state_next = pcp_pkg::ST_IDLE;
            default:
                state_next = pcp_pkg::ST_IDLE;
        endcase
        if (off_i)
        begin
            state_next = pcp_pkg::ST_IDLE;
            start_next = 1'b0;
        end
    end

    assign start_cycle_o = start_reg;
    assign power_en_o = (state_reg == pcp_pkg::ST_ON);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= pcp_pkg::ST_IDLE;
            cur_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            start_reg <= start_next;
        end
    end
endmodule

// ===== sim/pcp_disc_model.sv
`timescale 1ns/100ps
module pcp_disc_model (
    input wire logic clock_i, // System clock.
    input wire logic rst_b_i, // Asynchronous reset, active low.
    input wire logic [3:0] start_i, // Single cycle requests.
    input wire logic [3:0] kick_i, // Free-running cycle starts.
    input wire logic slow_i, // Selects the long classification.
    output logic [3:0] cls_active_o, // Classification running.
    output logic [3:0] cycle_done_o // Cycle finished pulses.
);
    // A request during a running cycle restarts it, as a real engine would.
    for (genvar n = 0; n < 4; n++)
    begin : g_ch
        logic [4:0] cnt_reg;
        always_ff @(posedge clock_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
                cnt_reg <= 5'h00;
            else if (start_i[n] || kick_i[n])
                cnt_reg <= slow_i ? 5'h0C : 5'h03;
            else if (cnt_reg != 5'h00)
                cnt_reg <= cnt_reg - 5'h01;
        end
        assign cls_active_o[n] = (cnt_reg != 5'h00);
        assign cycle_done_o[n] = (cnt_reg == 5'h01);
    end
endmodule

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb;
    typedef struct packed {logic [7:0] cmd; logic [3:0] power_enabled_status;} pcp_row_t;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] mode_i = 8'h55;
    logic [1:0] pair4_i = 2'h0;
    logic [1:0] single_sig_i = 2'h0;
    logic [3:0] high_class_i = 4'h0;
    logic [3:0] cls_valid_i = 4'hF;
    logic [3:0] alloc_ok_i = 4'hF;
    logic [3:0] kick = 4'h0;
    logic slow = 1'b0;
    logic [7:0] rdata_o;
    logic [3:0] done, active, start_cycle_o, power_en_o, chan_clear_o, cooldown_abort_o;
    logic reset_all_o, irq_b_o;
    logic [3:0] start_seen = 4'h0;
    logic [3:0] abort_seen = 4'h0;
    logic all_seen = 1'b0;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    pcp_row_t rows [5] = '{'{8'h0F, 4'hF}, '{8'h30, 4'hC}, '{8'h11, 4'hC},
        '{8'hC3, 4'h3}, '{8'hF0, 4'h0}};

    pcp_power_cmd #(.CLR_CYCLES(8)) uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .mode_i(mode_i), .pair4_i(pair4_i), .single_sig_i(single_sig_i),
        .high_class_i(high_class_i), .cycle_done_i(done), .cls_active_i(active),
        .cls_valid_i(cls_valid_i), .alloc_ok_i(alloc_ok_i), .start_cycle_o(start_cycle_o),
        .power_en_o(power_en_o), .chan_clear_o(chan_clear_o),
        .cooldown_abort_o(cooldown_abort_o), .reset_all_o(reset_all_o), .irq_b_o(irq_b_o));
    pcp_disc_model u_disc (.clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start_cycle_o),
        .kick_i(kick), .slow_i(slow), .cls_active_o(active), .cycle_done_o(done));

    always #2.5 clock_i = ~clock_i;

    // ==========================================================
    // Pulse catchers and hang guard
    always @(posedge clock_i)
    begin
        start_seen <= start_seen | start_cycle_o;
        abort_seen <= abort_seen | cooldown_abort_o;
        all_seen <= all_seen | reset_all_o;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        tick(1);
        wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        rd_i = 1'b1;
        addr_i = a;
        tick(1);
        rd_i = 1'b0;
        tick(1);
        chk(rdata_o, exp);
    endtask
    task automatic waitpe(input int c);
        for (int k = 0; k < 60 && power_en_o[c] !== 1'b1; k++)
            tick(1);
        chk({7'h00, power_en_o[c]}, 8'h01);
    endtask
    task automatic pulse_kick(input logic [3:0] k);
        kick = k;
        tick(1);
        kick = 4'h0;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        tick(3);
        rst_b_i = 1'b1;
        chk({3'h0, irq_b_o, power_en_o}, 8'h10);
        rd(8'h1A, 8'h00);
        rd(8'h7F, 8'h00);
        rd(8'h1E, 8'hFF);
        foreach (rows[i])
        begin
            wr(8'h19, rows[i].cmd);
            tick(10);
            rd(8'h10, {4'h0, rows[i].power_enabled_status});
        end
        rd(8'h02, 8'hFF);
        wr(8'h1A, 8'h00);
        tick(1);
        chk({7'h00, irq_b_o}, 8'h00);
        wr(8'h1A, 8'h40);
        tick(1);
        chk({7'h00, irq_b_o}, 8'h01);
        rd(8'h02, 8'hFF);
        wr(8'h02, 8'h0F);
        wr(8'h19, 8'h01);
        tick(2);
        chk({7'h00, irq_b_o}, 8'h01);
        wr(8'h1A, 8'h80);
        rd(8'h02, 8'h00);
        chk({7'h00, irq_b_o}, 8'h01);
        wr(8'h19, 8'h10);
        tick(2);
        chk({7'h00, irq_b_o}, 8'h00);
        tick(10);
        // Pass 0 turns channel 0 off by command, pass 1 by channel reset.
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h14, 8'hFF);
            wr(8'h1E, 8'h12);
            wr(8'h1F, 8'h34);
            wr(8'h19, 8'h03);
            tick(2);
            abort_seen = 4'h0;
            wr(k ? 8'h1A : 8'h19, k ? 8'h01 : 8'h10);
            tick(1);
            chk({4'h0, power_en_o}, 8'h02);
            chk({4'h0, chan_clear_o}, 8'h01);
            tick(5);
            chk({4'h0, chan_clear_o}, 8'h01);
            tick(3);
            chk({4'h0, chan_clear_o}, 8'h00);
            chk({4'h0, abort_seen}, {7'h00, k[0]});
            rd(8'h14, 8'hEE);
            rd(8'h1E, 8'hFF);
            rd(8'h1F, 8'h34);
        end
        pair4_i = 2'h1;
        wr(8'h19, 8'h03);
        abort_seen = 4'h0;
        wr(8'h1A, 8'h02);
        tick(3);
        chk({abort_seen, power_en_o}, 8'h30);
        tick(10);
        single_sig_i = 2'h1;
        high_class_i = 4'h3;
        wr(8'h19, 8'h03);
        wr(8'h19, 8'h20);
        tick(1);
        chk({4'h0, power_en_o}, 8'h00);
        tick(10);
        high_class_i = 4'h0;
        wr(8'h19, 8'h03);
        wr(8'h19, 8'h20);
        tick(1);
        chk({4'h0, power_en_o}, 8'h01);
        pair4_i = 2'h0;
        single_sig_i = 2'h0;
        tick(10);
        mode_i = 8'hE5;
        wr(8'h14, 8'h00);
        for (int k = 2; k < 4; k++)
        begin
            slow = k[0];
            start_seen = 4'h0;
            wr(8'h19, 8'h01 << k);
            waitpe(k);
            chk({4'h0, start_seen}, 8'h01 << k);
        end
        wr(8'h19, 8'hC0);
        tick(10);
        wr(8'h14, 8'hCC);
        pulse_kick(4'hC);
        tick(20);
        chk({4'h0, power_en_o}, 8'h09);
        wr(8'h19, 8'h04);
        pulse_kick(4'h4);
        waitpe(2);
        wr(8'h19, 8'hC0);
        tick(10);
        mode_i = 8'hF5;
        pair4_i = 2'h2;
        start_seen = 4'h0;
        wr(8'h19, 8'h08);
        tick(30);
        chk({start_seen, power_en_o}, 8'h01);
        mode_i = 8'hA5;
        wr(8'h19, 8'h0C);
        tick(30);
        wr(8'h19, 8'h80);
        start_seen = 4'h0;
        wr(8'h19, 8'h08);
        tick(1);
        chk({start_seen, power_en_o}, 8'h0D);
        wr(8'h1E, 8'h12);
        wr(8'h14, 8'h11);
        wr(8'h1A, 8'h10);
        tick(3);
        chk({3'h0, all_seen, power_en_o}, 8'h10);
        rd(8'h1E, 8'hFF);
        rd(8'h14, 8'h00);
        conclude();
    end
endmodule
